// ### logic/i2cirq_status.v
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "i2cirq_consts.vh"

module i2cirq_status (
	// Clock, reset and the enable that freezes every flop while low.
	input  wire        sys_clk,
	input  wire        rst_n,
	input  wire        clk_en,

	// Avalon-MM slave; only byte lanes 0 and 1 carry status bits.
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	output reg  [1:0]  avs_response,

	// One-cycle event pulses from the bus engine and the DMA.
	input  wire        ev_start_detect,
	input  wire        ev_stop_detect,
	input  wire        ev_arb_lost,
	input  wire        ev_nack,
	input  wire        ev_tx_dma_done,
	input  wire        ev_rx_dma_done,
	input  wire        ev_clock_timeout,
	input  wire        ev_master_done,
	input  wire        ev_next_byte_req,
	input  wire        ev_tx_request,

	// Levels from the FIFO engine; their flags set on a rising edge.
	input  wire        rx_fifo_full,
	input  wire        tx_fifo_empty,
	input  wire        rx_trigger_reached,
	input  wire        rx_fifo_has_data,
	input  wire        burst_count_zero,

	// Status words for the interrupt controller.
	output wire [11:0] raw_irq_status,
	output wire [11:0] masked_irq_status,
	output wire        irq
);

	// Status and mask storage.
	reg  [11:0] raw_irq_status_reg;
	reg  [11:0] irq_mask;
	reg         ack_pending;
	reg         tx_fe_prev;
	reg         rx_ff_prev;
	reg         rx_req_prev;
	reg  [11:0] next_raw;
	wire [11:0] set_ev;
	wire [11:0] clr_ev;
	wire        rx_req_cond;
	wire        wr_take;
	wire        rd_take;

	// Per-field clear strobes decoded from one accepted clear-register write.
	wire        master_intr_clear;
	wire        clock_timeout_clear;
	wire        rx_dma_done_clear;
	wire        tx_dma_done_clear;
	wire        nack_clear;
	wire        start_detect_clear;
	wire        stop_detect_clear;
	wire        arb_lost_clear;
	wire        tx_request_clear;
	wire        rx_request_clear;
	wire        tx_fifo_empty_clear;
	wire        rx_fifo_full_clear;

	// Named views of the stored raw flags.
	wire        raw_master_flag;
	wire        raw_clock_timeout_flag;
	wire        raw_rx_dma_done_flag;
	wire        raw_tx_dma_done_flag;
	wire        raw_nack_flag;
	wire        raw_start_detect_flag;
	wire        raw_stop_detect_flag;
	wire        raw_arb_lost_flag;
	wire        raw_tx_request_flag;
	wire        raw_rx_request_flag;
	wire        raw_tx_fifo_empty_flag;
	wire        raw_rx_fifo_full_flag;

	// Masked views of the FIFO flags and of the nine low flags.
	wire        masked_rx_request_flag;
	wire        masked_tx_fifo_empty_flag;
	wire        masked_rx_fifo_full_flag;
	wire [8:0]  masked_low;

	// True when an access addresses the given register offset.
	function hit;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	// Next value of one sticky flag. The set term sits outside the clear so an
	// event that lands in the clearing cycle is kept rather than lost.
	function flag_next;
		input cur_bit;
		input set_bit;
		input clr_bit;
		begin
			flag_next = set_bit | (cur_bit & ~clr_bit);
		end
	endfunction

	// True for the four implemented register offsets.
	function mapped;
		input [7:0] addr;
		begin
			mapped = hit(addr, `I2CIRQ_RAW_OFS) || hit(addr, `I2CIRQ_MASKED_OFS) ||
				hit(addr, `I2CIRQ_MASK_OFS) || hit(addr, `I2CIRQ_CLEAR_OFS);
		end
	endfunction

	// Each access waits one cycle so read data can be registered; the
	// second cycle drops waitrequest and the master samples then. A low clock
	// enable keeps waitrequest high, so no write is dropped while frozen.
	assign avs_waitrequest = (avs_read | avs_write) & ~(ack_pending & clk_en);
	assign wr_take         = avs_write & ack_pending & clk_en;
	assign rd_take         = avs_read & ~ack_pending & clk_en;

	// Receive request level condition. A hand-over from one source to the
	// other keeps it high and therefore is not a new set event.
	assign rx_req_cond = rx_trigger_reached | (rx_fifo_has_data & burst_count_zero);

	// Hardware set events. FIFO levels set only on their rising edge, so a
	// cleared flag stays down while the level itself persists.
	assign set_ev[`I2CIRQ_BIT_MASTER]  = ev_master_done | ev_next_byte_req;
	assign set_ev[`I2CIRQ_BIT_CLKTO]   = ev_clock_timeout;
	assign set_ev[`I2CIRQ_BIT_RXDMA]   = ev_rx_dma_done;
	assign set_ev[`I2CIRQ_BIT_TXDMA]   = ev_tx_dma_done;
	assign set_ev[`I2CIRQ_BIT_NACK]    = ev_nack;
	assign set_ev[`I2CIRQ_BIT_START]   = ev_start_detect;
	assign set_ev[`I2CIRQ_BIT_STOP]    = ev_stop_detect;
	assign set_ev[`I2CIRQ_BIT_ARBLOST] = ev_arb_lost;
	assign set_ev[`I2CIRQ_BIT_TXREQ]   = ev_tx_request;
	assign set_ev[`I2CIRQ_BIT_RXREQ]   = rx_req_cond & ~rx_req_prev;
	assign set_ev[`I2CIRQ_BIT_TXFE]    = tx_fifo_empty & ~tx_fe_prev;
	assign set_ev[`I2CIRQ_BIT_RXFF]    = rx_fifo_full & ~rx_ff_prev;

	// Write-one-to-clear strobes from the clear register, low two lanes only.
	assign clr_ev = (wr_take && hit(avs_address, `I2CIRQ_CLEAR_OFS)) ?
		(avs_writedata[11:0] & {{4{avs_byteenable[1]}}, {8{avs_byteenable[0]}}}) :
		12'h000;

	// Split the clear word into one strobe per field.
	assign master_intr_clear   = clr_ev[`I2CIRQ_BIT_MASTER];
	assign clock_timeout_clear = clr_ev[`I2CIRQ_BIT_CLKTO];
	assign rx_dma_done_clear   = clr_ev[`I2CIRQ_BIT_RXDMA];
	assign tx_dma_done_clear   = clr_ev[`I2CIRQ_BIT_TXDMA];
	assign nack_clear          = clr_ev[`I2CIRQ_BIT_NACK];
	assign start_detect_clear  = clr_ev[`I2CIRQ_BIT_START];
	assign stop_detect_clear   = clr_ev[`I2CIRQ_BIT_STOP];
	assign arb_lost_clear      = clr_ev[`I2CIRQ_BIT_ARBLOST];
	assign tx_request_clear    = clr_ev[`I2CIRQ_BIT_TXREQ];
	assign rx_request_clear    = clr_ev[`I2CIRQ_BIT_RXREQ];
	assign tx_fifo_empty_clear = clr_ev[`I2CIRQ_BIT_TXFE];
	assign rx_fifo_full_clear  = clr_ev[`I2CIRQ_BIT_RXFF];

	// Named views of the stored flags, used by the next-state and mask logic.
	assign raw_master_flag        = raw_irq_status_reg[`I2CIRQ_BIT_MASTER];
	assign raw_clock_timeout_flag = raw_irq_status_reg[`I2CIRQ_BIT_CLKTO];
	assign raw_rx_dma_done_flag   = raw_irq_status_reg[`I2CIRQ_BIT_RXDMA];
	assign raw_tx_dma_done_flag   = raw_irq_status_reg[`I2CIRQ_BIT_TXDMA];
	assign raw_nack_flag          = raw_irq_status_reg[`I2CIRQ_BIT_NACK];
	assign raw_start_detect_flag  = raw_irq_status_reg[`I2CIRQ_BIT_START];
	assign raw_stop_detect_flag   = raw_irq_status_reg[`I2CIRQ_BIT_STOP];
	assign raw_arb_lost_flag      = raw_irq_status_reg[`I2CIRQ_BIT_ARBLOST];
	assign raw_tx_request_flag    = raw_irq_status_reg[`I2CIRQ_BIT_TXREQ];
	assign raw_rx_request_flag    = raw_irq_status_reg[`I2CIRQ_BIT_RXREQ];
	assign raw_tx_fifo_empty_flag = raw_irq_status_reg[`I2CIRQ_BIT_TXFE];
	assign raw_rx_fifo_full_flag  = raw_irq_status_reg[`I2CIRQ_BIT_RXFF];

	// Set has priority over clear so an event in the clearing cycle survives;
	// only a write of one to the matching clear bit takes a flag down.
	always @* begin
		next_raw = `I2CIRQ_STATUS_RST;
		next_raw[`I2CIRQ_BIT_MASTER] = flag_next(raw_master_flag,
			set_ev[`I2CIRQ_BIT_MASTER], master_intr_clear);
		next_raw[`I2CIRQ_BIT_CLKTO] = flag_next(raw_clock_timeout_flag,
			set_ev[`I2CIRQ_BIT_CLKTO], clock_timeout_clear);
		next_raw[`I2CIRQ_BIT_RXDMA] = flag_next(raw_rx_dma_done_flag,
			set_ev[`I2CIRQ_BIT_RXDMA], rx_dma_done_clear);
		next_raw[`I2CIRQ_BIT_TXDMA] = flag_next(raw_tx_dma_done_flag,
			set_ev[`I2CIRQ_BIT_TXDMA], tx_dma_done_clear);
		next_raw[`I2CIRQ_BIT_NACK] = flag_next(raw_nack_flag,
			set_ev[`I2CIRQ_BIT_NACK], nack_clear);
		next_raw[`I2CIRQ_BIT_START] = flag_next(raw_start_detect_flag,
			set_ev[`I2CIRQ_BIT_START], start_detect_clear);
		next_raw[`I2CIRQ_BIT_STOP] = flag_next(raw_stop_detect_flag,
			set_ev[`I2CIRQ_BIT_STOP], stop_detect_clear);
		next_raw[`I2CIRQ_BIT_ARBLOST] = flag_next(raw_arb_lost_flag,
			set_ev[`I2CIRQ_BIT_ARBLOST], arb_lost_clear);
		next_raw[`I2CIRQ_BIT_TXREQ] = flag_next(raw_tx_request_flag,
			set_ev[`I2CIRQ_BIT_TXREQ], tx_request_clear);
		next_raw[`I2CIRQ_BIT_RXREQ] = flag_next(raw_rx_request_flag,
			set_ev[`I2CIRQ_BIT_RXREQ], rx_request_clear);
		next_raw[`I2CIRQ_BIT_TXFE] = flag_next(raw_tx_fifo_empty_flag,
			set_ev[`I2CIRQ_BIT_TXFE], tx_fifo_empty_clear);
		next_raw[`I2CIRQ_BIT_RXFF] = flag_next(raw_rx_fifo_full_flag,
			set_ev[`I2CIRQ_BIT_RXFF], rx_fifo_full_clear);
	end

	// Status flags and level history. The history flops reset low, so a
	// level that is already high when reset lifts gives one set event; the
	// interrupt controller sees it as pending rather than missing it.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			raw_irq_status_reg <= `I2CIRQ_STATUS_RST;
			tx_fe_prev         <= 1'b0;
			rx_ff_prev         <= 1'b0;
			rx_req_prev        <= 1'b0;
		end else if (clk_en) begin
			raw_irq_status_reg <= next_raw;
			tx_fe_prev         <= tx_fifo_empty;
			rx_ff_prev         <= rx_fifo_full;
			rx_req_prev        <= rx_req_cond;
		end
	end

	// Mask register, written with byte enables. The write is only taken on
	// the answering cycle, so a frozen clock enable cannot half-apply it.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= `I2CIRQ_MASK_RST;
		end else if (wr_take && hit(avs_address, `I2CIRQ_MASK_OFS)) begin
			if (avs_byteenable[0]) begin
				irq_mask[7:0] <= avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				irq_mask[11:8] <= avs_writedata[11:8];
			end
		end
	end

	// Masking and interrupt combine. The masked word is pure logic on the
	// raw flags and the mask, so one clear drops raw and masked together.
	assign raw_irq_status            = raw_irq_status_reg;
	assign masked_rx_request_flag    = raw_rx_request_flag & irq_mask[`I2CIRQ_BIT_RXREQ];
	assign masked_tx_fifo_empty_flag = raw_tx_fifo_empty_flag & irq_mask[`I2CIRQ_BIT_TXFE];
	assign masked_rx_fifo_full_flag  = raw_rx_fifo_full_flag & irq_mask[`I2CIRQ_BIT_RXFF];
	assign masked_low                = raw_irq_status_reg[8:0] & irq_mask[8:0];
	assign masked_irq_status         = {masked_rx_fifo_full_flag, masked_tx_fifo_empty_flag,
		masked_rx_request_flag, masked_low};
	assign irq                       = |masked_irq_status;

	// Bus handshake and registered read data. Unmapped reads return zero
	// with a decode-error response; writes to read-only words are ignored.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_pending  <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			avs_response <= 2'h0;
		end else if (clk_en) begin
			ack_pending <= (avs_read | avs_write) & ~ack_pending;
			if (rd_take) begin
				avs_response <= 2'h0;
				case (avs_address)
					`I2CIRQ_RAW_OFS: begin
						avs_readdata <= {20'h00000, raw_irq_status_reg};
					end
					`I2CIRQ_MASKED_OFS: begin
						avs_readdata <= {20'h00000, masked_irq_status};
					end
					`I2CIRQ_MASK_OFS: begin
						avs_readdata <= {20'h00000, irq_mask};
					end
					`I2CIRQ_CLEAR_OFS: begin
						avs_readdata <= 32'h0000_0000;
					end
					default: begin
						avs_readdata <= 32'h0000_0000;
						avs_response <= 2'h3;
					end
				endcase
			end else if (avs_write & ~ack_pending) begin
				avs_response <= mapped(avs_address) ? 2'h0 : 2'h3;
			end
		end
	end

endmodule // i2cirq_status

`default_nettype wire

// ### logic/i2cirq_consts.vh
`ifndef I2CIRQ_CONSTS_VH
`define I2CIRQ_CONSTS_VH

// Register byte offsets on the Avalon-MM slave.
`define I2CIRQ_RAW_OFS      8'h14
`define I2CIRQ_MASKED_OFS   8'h18
`define I2CIRQ_CLEAR_OFS    8'h1c
`define I2CIRQ_MASK_OFS     8'h10

// Field positions shared by the raw, masked, mask and clear registers.
`define I2CIRQ_BIT_MASTER   0
`define I2CIRQ_BIT_CLKTO    1
`define I2CIRQ_BIT_RXDMA    2
`define I2CIRQ_BIT_TXDMA    3
`define I2CIRQ_BIT_NACK     4
`define I2CIRQ_BIT_START    5
`define I2CIRQ_BIT_STOP     6
`define I2CIRQ_BIT_ARBLOST  7
`define I2CIRQ_BIT_TXREQ    8
`define I2CIRQ_BIT_RXREQ    9
`define I2CIRQ_BIT_TXFE     10
`define I2CIRQ_BIT_RXFF     11

// Number of implemented status bits; bits above read as zero.
`define I2CIRQ_NBITS        12

// Reset values.
`define I2CIRQ_STATUS_RST   12'h000
`define I2CIRQ_MASK_RST     12'h000

`endif

// ### sim/i2cirq_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches flag set, hold and masking relations at the block's ports.
module i2cirq_chk (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        ev_start_detect,
	input wire logic        ev_nack,
	input wire logic        ev_clock_timeout,
	input wire logic        ev_master_done,
	input wire logic        ev_next_byte_req,
	input wire logic [11:0] raw_irq_status,
	input wire logic [11:0] masked_irq_status,
	input wire logic        irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// The slave stalls one cycle, then answers.
	sequence s_ack;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	AST_ACK: assert property ($rose(avs_read | avs_write) |-> s_ack) else $error("late answer");
	AST_START: assert property (ev_start_detect |=> raw_irq_status[5]) else $error("start");
	AST_NACK: assert property (ev_nack |=> raw_irq_status[4]) else $error("nack");
	AST_CLKTO: assert property (ev_clock_timeout |=> raw_irq_status[1]) else $error("clk");
	AST_MASTER: assert property (ev_master_done || ev_next_byte_req |=> raw_irq_status[0])
		else $error("master");
	// Only a write can take the pending NACK flag away.
	AST_HOLD: assert property (raw_irq_status[4] && !avs_write |=> raw_irq_status[4])
		else $error("nack lost");
	AST_MASKED: assert property ((masked_irq_status & ~raw_irq_status) == 12'h000)
		else $error("masked");
	AST_IRQ: assert property (irq == |masked_irq_status) else $error("irq");
endmodule // i2cirq_chk
bind i2cirq_status i2cirq_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .ev_start_detect(ev_start_detect),
	.ev_nack(ev_nack), .ev_clock_timeout(ev_clock_timeout), .ev_master_done(ev_master_done),
	.ev_next_byte_req(ev_next_byte_req), .raw_irq_status(raw_irq_status),
	.masked_irq_status(masked_irq_status), .irq(irq));
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2cirq_consts.vh"
module tb;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        en = 1'b1;
	logic [7:0]  adr = 8'h00;
	logic        rd_q = 1'b0;
	logic        wr_q = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] q;
	logic [9:0]  ev = 10'h000;
	logic [4:0]  lv = 5'h00;
	wire  [31:0] rdata;
	wire         wait_q;
	wire  [1:0]  resp;
	wire  [11:0] raw;
	wire  [11:0] msk;
	wire         irq;
	int          bad_count = 0;
	int          check_count = 0;
	// Byte lanes stay enabled; the clock enable is dropped once to check the freeze.
	i2cirq_status i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(en), .avs_address(adr),
		.avs_read(rd_q), .avs_write(wr_q), .avs_writedata(wd), .avs_byteenable(4'hf),
		.avs_readdata(rdata), .avs_waitrequest(wait_q), .avs_response(resp),
		.ev_master_done(ev[0]), .ev_clock_timeout(ev[1]), .ev_rx_dma_done(ev[2]),
		.ev_tx_dma_done(ev[3]), .ev_nack(ev[4]), .ev_start_detect(ev[5]),
		.ev_stop_detect(ev[6]), .ev_arb_lost(ev[7]), .ev_tx_request(ev[8]),
		.ev_next_byte_req(ev[9]), .rx_fifo_full(lv[0]), .tx_fifo_empty(lv[1]),
		.rx_trigger_reached(lv[2]), .rx_fifo_has_data(lv[3]), .burst_count_zero(lv[4]),
		.raw_irq_status(raw), .masked_irq_status(msk), .irq(irq));
	always #2.5 sys_clk = ~sys_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Request holds until waitrequest is sampled low at a rising edge; events drop with it.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		adr <= a;
		wd <= d;
		wr_q <= w;
		rd_q <= !w;
		@(posedge sys_clk);
		while (wait_q) @(posedge sys_clk);
		q = rdata;
		{wr_q, rd_q, ev} <= 12'h000;
		@(posedge sys_clk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task pls(input logic [9:0] v);
		ev <= v;
		@(posedge sys_clk);
		ev <= 10'h000;
		repeat (2) @(posedge sys_clk);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rd(`I2CIRQ_RAW_OFS, 32'h0);
		rd(`I2CIRQ_MASKED_OFS, 32'h0);
		rd(8'h40, 32'h0);
		chk(resp, 32'h3);
		$display("test reset done");
		bus(1'b1, `I2CIRQ_MASK_OFS, 32'hfff);
		pls(10'h1ff);
		bus(1'b1, `I2CIRQ_RAW_OFS, 32'h0);
		rd(`I2CIRQ_RAW_OFS, 32'h1ff);
		rd(`I2CIRQ_MASKED_OFS, 32'h1ff);
		chk(irq, 32'h1);
		bus(1'b1, `I2CIRQ_MASK_OFS, 32'h0f0);
		rd(`I2CIRQ_MASK_OFS, 32'h0f0);
		rd(`I2CIRQ_MASKED_OFS, 32'h0f0);
		bus(1'b1, `I2CIRQ_MASK_OFS, 32'hfff);
		for (int i = 0; i < 9; i++) begin
			bus(1'b1, `I2CIRQ_CLEAR_OFS, 32'h1 << i);
			rd(`I2CIRQ_RAW_OFS, (32'h1ff << (i + 1)) & 32'h1ff);
		end
		chk(irq, 32'h0);
		pls(10'h200);
		rd(`I2CIRQ_RAW_OFS, 32'h1);
		bus(1'b1, `I2CIRQ_CLEAR_OFS, 32'h1);
		ev <= 10'h010;
		bus(1'b1, `I2CIRQ_CLEAR_OFS, 32'h10);
		rd(`I2CIRQ_RAW_OFS, 32'h10);
		bus(1'b1, `I2CIRQ_CLEAR_OFS, 32'h10);
		en <= 1'b0;
		pls(10'h040);
		en <= 1'b1;
		rd(`I2CIRQ_RAW_OFS, 32'h0);
		$display("test pulse flags done");
		lv <= 5'h07;
		repeat (2) @(posedge sys_clk);
		rd(`I2CIRQ_MASKED_OFS, 32'he00);
		bus(1'b1, `I2CIRQ_CLEAR_OFS, 32'he00);
		rd(`I2CIRQ_RAW_OFS, 32'h0);
		lv <= 5'h00;
		repeat (2) @(posedge sys_clk);
		lv <= 5'h18;
		repeat (2) @(posedge sys_clk);
		bus(1'b1, `I2CIRQ_MASK_OFS, 32'h0);
		rd(`I2CIRQ_RAW_OFS, 32'h200);
		rd(`I2CIRQ_MASKED_OFS, 32'h0);
		chk(irq, 32'h0);
		$display("test fifo flags done");
		bus(1'b1, `I2CIRQ_MASK_OFS, 32'hfff);
		chk(irq, 32'h1);
		lv <= 5'h00;
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		chk(irq, 32'h0);
		rd(`I2CIRQ_RAW_OFS, 32'h0);
		rd(`I2CIRQ_MASKED_OFS, 32'h0);
		rd(`I2CIRQ_MASK_OFS, 32'h0);
		$display("test mid-run reset done");
		print_verdict;
	end
	// Watchdog: the tests need well under a thousand cycles.
	initial begin
		#50000;
		bad_count++;
		$display("ERROR %0t watchdog expired", $time);
		print_verdict;
	end
endmodule // tb
`default_nettype wire
